// ===== dar_pkg.sv
package dar_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] A_LOCK = 16'h013C;
  localparam logic [15:0] A_URST = 16'h0410;
  localparam logic [15:0] A_WIN = 16'h0800;
  localparam logic [15:0] LOCK_MAX = 16'h0001;
  localparam logic [15:0] URST_MAX = 16'h0007;
  localparam int URST_GO = 0;
  localparam int NPAR = 8;
  localparam logic [2:0] LAST_IDX = 3'h7;
  localparam logic [7:0] PROT_MASK = 8'h0F;
  localparam logic [2:0] IDX_SCALE = 3'h4;
  localparam logic [15:0] USR_PER_REV = 16'h000C;
  // ----------------------------------------
  // Position range, -786432 .. 786431
  // ----------------------------------------
  localparam logic signed [31:0] POS_MIN = 32'shFFF40000;
  localparam logic signed [31:0] POS_MAX = 32'sh000BFFFF;
  localparam logic signed [32:0] SPAN = 33'sh000180000;
  localparam logic signed [47:0] INC_PER_REV = 48'sh000000008000;
  // ----------------------------------------
  // Channels, modes, move kinds
  // ----------------------------------------
  localparam logic [1:0] CH_FB = 2'h0;
  localparam logic [1:0] CH_CS = 2'h1;
  localparam logic [1:0] CH_DI = 2'h2;
  localparam logic [1:0] CH_WEB = 2'h3;
  localparam logic [2:0] MD_JOG = 3'h1;
  localparam logic [2:0] MD_PP = 3'h2;
  localparam logic [2:0] MD_HOME = 3'h3;
  localparam logic [2:0] MD_CSP = 3'h4;
  localparam logic [2:0] K_CONT = 3'h0;
  localparam logic [2:0] K_STEP = 3'h1;
  localparam logic [2:0] K_REL = 3'h2;
  localparam logic [2:0] K_ABS = 3'h3;
  localparam logic [2:0] K_SET = 3'h4;
  localparam logic [2:0] K_REF = 3'h5;
  typedef enum logic [2:0] {
    OWN_NONE = 3'b001,
    OWN_FB = 3'b010,
    OWN_CS = 3'b100
  } dar_own_t;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_RUN = 2'b10
  } dar_sw_t;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] par_default(input logic [2:0] i);
    case (i)
      3'h0: return 16'h0001;
      IDX_SCALE: return USR_PER_REV;
      default: return 16'h0000;
    endcase
  endfunction : par_default
  function automatic logic in_rng(input logic signed [32:0] v);
    return v >= 33'(POS_MIN) && v <= 33'(POS_MAX);
  endfunction : in_rng
  function automatic logic ch_ok(input dar_own_t o, input logic [1:0] c);
    case (o)
      OWN_NONE: return 1'b1;
      OWN_FB: return c != CH_CS && c != CH_DI;
      OWN_CS: return c == CH_CS;
      default: return 1'b0;
    endcase
  endfunction : ch_ok
  function automatic logic signed [47:0] usr_to_inc(input logic signed [31:0] p,
                                                    input logic [15:0] s);
    logic [15:0] d;
    d = (s == 16'h0000) ? 16'h0001 : s;
    return (48'(p) * INC_PER_REV) / $signed({32'h00000000, d});
  endfunction : usr_to_inc
endpackage : dar_pkg

// ===== dar_store_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dar_store_if;
  logic wr;
  logic [2:0] wr_idx;
  logic [15:0] wr_data;
  logic [2:0] rd_idx;
  logic [15:0] rd_data;
  modport ctl(output wr, wr_idx, wr_data, rd_idx, input rd_data);
  modport mem(input wr, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : dar_store_if
`default_nettype wire

// ===== dar_store.sv
`timescale 1ns/1ps
`default_nettype none
module dar_store import dar_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Access port
  dar_store_if.mem bus
);
  typedef struct packed {
    logic [NPAR-1:0][15:0] mem;
    logic [15:0] rd;
  } dar_mst_t;
  dar_mst_t r;
  dar_mst_t n;
  // ----------------------------------------
  // Parameter words, defaults on reset
  // ----------------------------------------
  always_comb begin
    n = r;
    if (bus.wr) begin
      n.mem[bus.wr_idx] = bus.wr_data;
    end
    n.rd = r.mem[bus.rd_idx];
    if (!nrst_in) begin
      for (int i = 0; i < NPAR; i++) begin
        n.mem[i] = par_default(3'(i));
      end
      n.rd = 16'h0000;
    end
  end
  always_ff @(posedge clk_in) begin
    r <= n;
  end
  assign bus.rd_data = r.rd;
endmodule : dar_store
`default_nettype wire

// ===== dar_top.sv
`timescale 1ns/1ps
`default_nettype none
module dar_top import dar_pkg::*; (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Parameter port
  input wire logic PAR_WR_IN,
  input wire logic PAR_RD_IN,
  input wire logic [15:0] PAR_ADDR_IN,
  input wire logic [15:0] PAR_WDATA_IN,
  output logic [15:0] PAR_RDATA_OUT,
  output logic PAR_ACK_OUT,
  output logic PAR_ERR_OUT,
  // Channels and commands
  input wire logic CS_EXCL_SW_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [1:0] CMD_CHAN_IN,
  input wire logic [2:0] CMD_KIND_IN,
  input wire logic signed [31:0] CMD_TARGET_IN,
  input wire logic [2:0] MODE_IN,
  output logic [2:0] OWNER_OUT,
  output logic CMD_BLOCK_OUT,
  // Always-on inputs
  input wire logic [7:0] SAFE_IN,
  output logic [7:0] SAFE_OUT,
  // Power stage and storage
  input wire logic PWR_EN_IN,
  input wire logic NV_SAVE_IN,
  input wire logic FACTORY_IN,
  output logic NV_SAVE_OUT,
  output logic NV_ERASE_OUT,
  output logic CYCLE_REQ_OUT,
  output logic APPLY_OUT,
  output logic BUSY_OUT,
  // Position
  output logic signed [31:0] POS_OUT,
  output logic signed [47:0] POS_INC_OUT,
  output logic MOVE_GO_OUT,
  output logic MOVE_REJ_OUT,
  output logic ZERO_VALID_OUT
);
  typedef struct packed {
    dar_own_t own;
    dar_sw_t sw;
    logic [2:0] sidx;
    logic lock;
    logic [15:0] urst;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic rpend;
    logic blk;
    logic [7:0] safe;
    logic pwr_d;
    logic apend;
    logic apply;
    logic [15:0] scale_sh;
    logic [15:0] scale;
    logic nvs;
    logic nve;
    logic cyc;
    logic [31:0] pos;
    logic [47:0] pinc;
    logic go;
    logic rej;
    logic zv;
  } dar_st_t;
  localparam dar_st_t ST_RST = '{own: OWN_NONE, sw: SW_IDLE,
                                 scale_sh: USR_PER_REV, scale: USR_PER_REV,
                                 default: '0};
  dar_st_t r;
  dar_st_t n;
  logic m_wr;
  logic [2:0] m_idx;
  logic [15:0] m_wd;
  logic hit_win;
  logic [2:0] widx;
  logic ok;
  logic signed [32:0] sum;
  logic signed [32:0] tgt;
  dar_store_if sif();
  dar_store u_store (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .bus(sif)
  );
  assign sif.wr = m_wr;
  assign sif.wr_idx = m_idx;
  assign sif.wr_data = m_wd;
  assign sif.rd_idx = PAR_ADDR_IN[4:2];
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    {n.ack, n.err, n.blk, n.go, n.rej, n.nvs, n.nve, n.apply} = 8'h00;
    m_wr = 1'b0;
    m_idx = r.sidx;
    m_wd = par_default(r.sidx);
    hit_win = PAR_ADDR_IN[15:5] == A_WIN[15:5] && PAR_ADDR_IN[1:0] == 2'h0;
    widx = PAR_ADDR_IN[4:2];
    tgt = 33'(CMD_TARGET_IN);
    sum = 33'($signed(r.pos)) + tgt;
    ok = ch_ok(r.own, CMD_CHAN_IN);
    // Sampled and passed on whatever the owner is
    n.safe = SAFE_IN;
    n.pwr_d = PWR_EN_IN;
    // Parameter port; one access in flight at a time
    if (r.rpend) begin
      n.rpend = 1'b0;
      n.ack = 1'b1;
      n.rdata = sif.rd_data;
    end else if (PAR_WR_IN) begin
      n.ack = 1'b1;
      if (PAR_ADDR_IN == A_LOCK) begin
        // Software holding the switch keeps the fieldbus out
        if (PAR_WDATA_IN > LOCK_MAX || r.own == OWN_CS) begin
          n.err = 1'b1;
        end else begin
          n.lock = PAR_WDATA_IN[0];
        end
      end else if (PAR_ADDR_IN == A_URST) begin
        if (PAR_WDATA_IN > URST_MAX || PWR_EN_IN || r.sw != SW_IDLE) begin
          n.err = 1'b1;
        end else begin
          n.urst = PAR_WDATA_IN;
          if (PAR_WDATA_IN[URST_GO]) begin
            n.sw = SW_RUN;
            n.sidx = 3'h0;
          end
        end
      end else if (hit_win && r.sw == SW_IDLE) begin
        m_wr = 1'b1;
        m_idx = widx;
        m_wd = PAR_WDATA_IN;
        if (widx == IDX_SCALE) begin
          n.scale_sh = PAR_WDATA_IN;
        end
      end else begin
        n.err = 1'b1;
      end
    end else if (PAR_RD_IN) begin
      n.ack = 1'b1;
      n.rdata = 16'h0000;
      if (PAR_ADDR_IN == A_LOCK) begin
        n.rdata = {15'h0000, r.lock};
      end else if (PAR_ADDR_IN == A_URST) begin
        n.rdata = r.urst;
      end else if (hit_win) begin
        // Store read data come a cycle later
        n.ack = 1'b0;
        n.rpend = 1'b1;
      end else begin
        n.err = 1'b1;
      end
    end
    // New settings become active at the enable edge
    if (PWR_EN_IN && !r.pwr_d) begin
      n.scale = r.scale_sh;
      n.apply = r.apend;
      n.apend = 1'b0;
    end
    // ----------------------------------------
    // Default sweep, one word per cycle
    // ----------------------------------------
    case (r.sw)
      SW_IDLE: begin
      end
      SW_RUN: begin
        if (!PROT_MASK[r.sidx]) begin
          m_wr = 1'b1;
          if (r.sidx == IDX_SCALE) begin
            n.scale_sh = par_default(r.sidx);
          end
        end
        n.sidx = r.sidx + 3'h1;
        if (r.sidx == LAST_IDX) begin
          n.sw = SW_IDLE;
          n.apend = 1'b1;
        end
      end
      default: n.sw = SW_IDLE;
    endcase
    // A save during the sweep would store half-reset values
    n.nvs = NV_SAVE_IN && r.sw == SW_IDLE;
    if (FACTORY_IN && !PWR_EN_IN) begin
      n.nve = 1'b1;
      n.cyc = 1'b1;
    end
    // ----------------------------------------
    // Exclusive access
    // ----------------------------------------
    case (r.own)
      OWN_NONE: begin
        if (n.lock) begin
          n.own = OWN_FB;
        end else if (CS_EXCL_SW_IN) begin
          n.own = OWN_CS;
        end
      end
      OWN_FB: begin
        if (!n.lock) begin
          n.own = OWN_NONE;
        end
      end
      OWN_CS: begin
        if (!CS_EXCL_SW_IN) begin
          n.own = OWN_NONE;
        end
      end
      default: n.own = OWN_NONE;
    endcase
    // ----------------------------------------
    // Commands and movement range
    // ----------------------------------------
    if (CMD_VALID_IN) begin
      if (!ok) begin
        n.blk = 1'b1;
      end else begin
        case (CMD_KIND_IN)
          K_CONT: begin
            if (MODE_IN != MD_JOG) begin
              n.rej = 1'b1;
            end else begin
              n.go = 1'b1;
              n.pos = 32'(sum);
              // Wraps once; a single step must be shorter than the range
              if (sum > 33'(POS_MAX)) begin
                n.pos = 32'(sum - SPAN);
                n.zv = 1'b0;
              end else if (sum < 33'(POS_MIN)) begin
                n.pos = 32'(sum + SPAN);
                n.zv = 1'b0;
              end
            end
          end
          K_STEP, K_REL: begin
            if (!in_rng(tgt) || !((CMD_KIND_IN == K_STEP && MODE_IN == MD_JOG) ||
                                   (CMD_KIND_IN == K_REL && MODE_IN == MD_PP))) begin
              n.rej = 1'b1;
            end else begin
              n.go = 1'b1;
              if (in_rng(sum)) begin
                n.pos = 32'(sum);
              end else begin
                n.pos = 32'(tgt);
                n.zv = 1'b0;
              end
            end
          end
          K_ABS: begin
            if ((MODE_IN != MD_PP && MODE_IN != MD_CSP) || !in_rng(tgt)) begin
              n.rej = 1'b1;
            end else begin
              n.go = 1'b1;
              n.pos = 32'(tgt);
            end
          end
          K_SET, K_REF: begin
            if (MODE_IN != MD_HOME || !in_rng(tgt)) begin
              n.rej = 1'b1;
            end else begin
              n.go = 1'b1;
              n.pos = 32'(tgt);
              n.zv = 1'b1;
            end
          end
          default: n.rej = 1'b1;
        endcase
      end
    end
    // Same user value, new increments after a scaling change
    n.pinc = usr_to_inc($signed(n.pos), n.scale);
  end
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PAR_RDATA_OUT = r.rdata;
  assign PAR_ACK_OUT = r.ack;
  assign PAR_ERR_OUT = r.err;
  assign OWNER_OUT = r.own;
  assign CMD_BLOCK_OUT = r.blk;
  assign SAFE_OUT = r.safe;
  assign NV_SAVE_OUT = r.nvs;
  assign NV_ERASE_OUT = r.nve;
  assign CYCLE_REQ_OUT = r.cyc;
  assign APPLY_OUT = r.apply;
  // One-hot run bit, so the output is the flop itself
  assign BUSY_OUT = r.sw[1];
  assign POS_OUT = $signed(r.pos);
  assign POS_INC_OUT = $signed(r.pinc);
  assign MOVE_GO_OUT = r.go;
  assign MOVE_REJ_OUT = r.rej;
  assign ZERO_VALID_OUT = r.zv;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic wr_u;
  assign wr_u = PAR_WR_IN && !r.rpend && PAR_ADDR_IN == A_URST;
  property p_urst_go;
    wr_u && PAR_WDATA_IN[0] && PAR_WDATA_IN <= URST_MAX && !PWR_EN_IN && !BUSY_OUT
      |=> BUSY_OUT && !PAR_ERR_OUT ##8 !BUSY_OUT;
  endproperty
  a_urst_go: assert property (p_urst_go) else $error("user reset sweep wrong");
  property p_prot;
    r.sw == SW_RUN && PROT_MASK[r.sidx] |-> !m_wr;
  endproperty
  a_prot: assert property (p_prot) else $error("protected word written");
  property p_range;
    wr_u && PAR_WDATA_IN > URST_MAX |=> PAR_ERR_OUT && PAR_ACK_OUT;
  endproperty
  a_range: assert property (p_range) else $error("value above 7 taken");
  property p_nosave;
    BUSY_OUT |=> !NV_SAVE_OUT;
  endproperty
  a_nosave: assert property (p_nosave) else $error("save during sweep");
  property p_pwr;
    wr_u && PWR_EN_IN && !BUSY_OUT |=> PAR_ERR_OUT && !BUSY_OUT;
  endproperty
  a_pwr: assert property (p_pwr) else $error("reset taken while enabled");
  property p_one;
    $onehot(OWNER_OUT);
  endproperty
  a_one: assert property (p_one) else $error("owner not one-hot");
  property p_lock;
    PAR_WR_IN && !r.rpend && PAR_ADDR_IN == A_LOCK && PAR_WDATA_IN == 16'h0001
      && OWNER_OUT != OWN_CS |=> OWNER_OUT == OWN_FB && !PAR_ERR_OUT;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not granted");
  property p_block;
    CMD_VALID_IN && OWNER_OUT == OWN_FB && (CMD_CHAN_IN == CH_DI || CMD_CHAN_IN == CH_CS)
      |=> CMD_BLOCK_OUT && !MOVE_GO_OUT && $stable(POS_OUT);
  endproperty
  a_block: assert property (p_block) else $error("locked channel served");
  property p_safe;
    ##1 SAFE_OUT == $past(SAFE_IN);
  endproperty
  a_safe: assert property (p_safe) else $error("safety input lost");
  property p_step;
    CMD_VALID_IN && ok && MODE_IN == MD_JOG && CMD_KIND_IN == K_STEP && in_rng(tgt)
      && !in_rng(sum) |=> POS_OUT == $past(CMD_TARGET_IN) && !ZERO_VALID_OUT;
  endproperty
  a_step: assert property (p_step) else $error("step not rezeroed");
  property p_abs;
    CMD_VALID_IN && ok && MODE_IN == MD_PP && CMD_KIND_IN == K_ABS && !in_rng(tgt)
      |=> MOVE_REJ_OUT && !MOVE_GO_OUT;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute move not refused");
  property p_zero;
    $rose(ZERO_VALID_OUT) |-> $past(MODE_IN) == MD_HOME;
  endproperty
  a_zero: assert property (p_zero) else $error("zero set outside homing");
  c_sweep: cover property (BUSY_OUT ##1 !BUSY_OUT ##[1:20] APPLY_OUT);
  c_wrap: cover property (MOVE_GO_OUT && $fell(ZERO_VALID_OUT));
  c_cs: cover property (OWNER_OUT == OWN_CS ##1 CMD_BLOCK_OUT);
endmodule : dar_top
`default_nettype wire

// ===== dar_host.sv
`timescale 1ns/1ps
`default_nettype none
module dar_host (
  // Clock
  input wire logic clk_in,
  // Parameter port
  output logic par_wr_out,
  output logic par_rd_out,
  output logic [15:0] par_addr_out,
  output logic [15:0] par_wdata_out,
  input wire logic [15:0] par_rdata_in,
  input wire logic par_ack_in,
  input wire logic par_err_in,
  // Software exclusive switch
  output logic cs_excl_out
);
  initial begin
    par_wr_out = 1'b0;
    par_rd_out = 1'b0;
    par_addr_out = 16'h0000;
    par_wdata_out = 16'h0000;
    cs_excl_out = 1'b0;
  end
  // ----------------------------------------
  // One access at a time, strobe one cycle
  // ----------------------------------------
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    par_wr_out = wr;
    par_rd_out = !wr;
    par_addr_out = addr;
    par_wdata_out = wdata;
    @(posedge clk_in);
    #1;
    par_wr_out = 1'b0;
    par_rd_out = 1'b0;
    while (par_ack_in !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    rdata = par_rdata_in;
    err = (n < 8) ? par_err_in : 1'bx;
    // Released lines show garbage, not the old value
    par_addr_out = ~addr;
    par_wdata_out = ~wdata;
  endtask : access
  // Switch flips just after an edge
  task automatic excl(input logic on);
    @(posedge clk_in);
    #1;
    cs_excl_out = on;
  endtask : excl
endmodule : dar_host
`default_nettype wire

// ===== drive_access_position_range_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module drive_access_position_range_test;
  import dar_pkg::*;
  logic clk, nrst, pwr_en, nv_save, factory, cmd_valid;
  logic par_wr, par_rd, par_ack, par_err, cs_excl;
  logic [15:0] par_addr, par_wdata, par_rdata;
  logic [1:0] cmd_chan;
  logic [2:0] cmd_kind, mode, owner;
  logic signed [31:0] cmd_target, pos;
  logic signed [47:0] pos_inc;
  logic [7:0] safe_in, safe_out;
  logic blk, nvs_out, erase, cyc_req, apply, busy, go, rej, zero;
  logic [15:0] rd;
  logic er;
  logic [2:0] r;
  int fails = 0, n_compared = 0, n_apply = 0, n_save = 0, n_erase = 0;
  dar_top i_dut (.CLK_IN(clk), .NRST_IN(nrst), .PAR_WR_IN(par_wr), .PAR_RD_IN(par_rd),
    .PAR_ADDR_IN(par_addr), .PAR_WDATA_IN(par_wdata), .PAR_RDATA_OUT(par_rdata),
    .PAR_ACK_OUT(par_ack), .PAR_ERR_OUT(par_err), .CS_EXCL_SW_IN(cs_excl),
    .CMD_VALID_IN(cmd_valid), .CMD_CHAN_IN(cmd_chan), .CMD_KIND_IN(cmd_kind),
    .CMD_TARGET_IN(cmd_target), .MODE_IN(mode), .OWNER_OUT(owner), .CMD_BLOCK_OUT(blk),
    .SAFE_IN(safe_in), .SAFE_OUT(safe_out), .PWR_EN_IN(pwr_en), .NV_SAVE_IN(nv_save),
    .FACTORY_IN(factory), .NV_SAVE_OUT(nvs_out), .NV_ERASE_OUT(erase),
    .CYCLE_REQ_OUT(cyc_req), .APPLY_OUT(apply), .BUSY_OUT(busy), .POS_OUT(pos),
    .POS_INC_OUT(pos_inc), .MOVE_GO_OUT(go), .MOVE_REJ_OUT(rej), .ZERO_VALID_OUT(zero));
  dar_host i_host (.clk_in(clk), .par_wr_out(par_wr), .par_rd_out(par_rd),
    .par_addr_out(par_addr), .par_wdata_out(par_wdata), .par_rdata_in(par_rdata),
    .par_ack_in(par_ack), .par_err_in(par_err), .cs_excl_out(cs_excl));
  // ----------------------------------------
  // Clock, pulse counters, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) begin
    n_apply += (apply === 1'b1);
    n_save += (nvs_out === 1'b1);
    n_erase += (erase === 1'b1);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic cmd(input logic [1:0] ch, input logic [2:0] k, input logic [2:0] md,
                     input logic signed [31:0] t);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_chan = ch;
    cmd_kind = k;
    mode = md;
    cmd_target = t;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    r = {go, rej, blk};
    if (r === 3'h0) begin
      @(posedge clk);
      #1;
      r = {go, rej, blk};
    end
  endtask : cmd
  task automatic end_sim();
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_position();
    `CHK(owner, 3'h1)
    cmd(CH_FB, K_REF, MD_PP, 32'sh7);
    `CHK(r, 3'h2)
    `CHK(zero, 1'b0)
    cmd(CH_FB, K_SET, MD_HOME, 32'sh5);
    `CHK(r, 3'h4)
    `CHK({pos, zero}, {32'sh5, 1'b1})
    `CHK(pos_inc, 48'sd13653)
    cmd(CH_FB, K_ABS, MD_PP, 32'sd786432);
    `CHK({r, pos}, {3'h2, 32'sh5})
    cmd(CH_FB, K_ABS, MD_PP, 32'sd786431);
    `CHK({r, pos}, {3'h4, 32'sd786431})
    cmd(CH_FB, K_CONT, MD_JOG, 32'sh1);
    `CHK({r, pos}, {3'h4, -32'sd786432})
    `CHK(zero, 1'b0)
    cmd(CH_FB, K_SET, MD_HOME, 32'sd786431);
    cmd(CH_FB, K_STEP, MD_JOG, 32'sh1);
    `CHK({r, pos, zero}, {3'h4, 32'sh1, 1'b0})
    cmd(CH_FB, K_REF, MD_HOME, -32'sd786432);
    `CHK({r, zero}, {3'h4, 1'b1})
    cmd(CH_FB, K_REL, MD_PP, -32'sh2);
    `CHK({r, pos, zero}, {3'h4, -32'sh2, 1'b0})
    cmd(CH_FB, K_ABS, MD_CSP, 32'sh2A);
    `CHK({r, pos}, {3'h4, 32'sh2A})
    cmd(CH_FB, K_ABS, 3'h0, 32'sh3);
    `CHK({r, pos}, {3'h2, 32'sh2A})
  endtask : t_position
  task automatic t_lock();
    i_host.access(1'b1, A_LOCK, 16'h0001, rd, er);
    `CHK({er, owner}, {1'b0, 3'h2})
    cmd(CH_CS, K_SET, MD_HOME, 32'sh9);
    `CHK({r, pos}, {3'h1, 32'sh2A})
    cmd(CH_DI, K_CONT, MD_JOG, 32'sh1);
    `CHK(r, 3'h1)
    cmd(CH_WEB, K_SET, MD_HOME, 32'sh9);
    `CHK({r, pos}, {3'h4, 32'sh9})
    safe_in = 8'hA5;
    cyc(2);
    `CHK(safe_out, 8'hA5)
    i_host.access(1'b1, A_LOCK, 16'h0002, rd, er);
    `CHK(er, 1'b1)
    i_host.access(1'b0, A_LOCK, 16'h0000, rd, er);
    `CHK({er, rd}, {1'b0, 16'h0001})
    i_host.access(1'b1, A_LOCK, 16'h0000, rd, er);
    `CHK(owner, 3'h1)
  endtask : t_lock
  task automatic t_software();
    i_host.excl(1'b1);
    cyc(2);
    `CHK(owner, 3'h4)
    i_host.access(1'b1, A_LOCK, 16'h0001, rd, er);
    `CHK({er, owner}, {1'b1, 3'h4})
    cmd(CH_FB, K_SET, MD_HOME, 32'sh3);
    `CHK(r, 3'h1)
    safe_in = 8'h5A;
    cmd(CH_CS, K_SET, MD_HOME, 32'sh3);
    `CHK({r, pos, safe_out}, {3'h4, 32'sh3, 8'h5A})
    i_host.excl(1'b0);
    cyc(2);
    `CHK(owner, 3'h1)
  endtask : t_software
  task automatic t_user_reset();
    int n, a, s;
    i_host.access(1'b1, A_WIN, 16'h0005, rd, er);
    i_host.access(1'b1, A_WIN + 16'h0010, 16'h0018, rd, er);
    a = n_apply;
    pwr_en = 1'b1;
    cyc(3);
    // No user reset pending yet, so no apply pulse
    `CHK(n_apply - a, 0)
    cmd(CH_FB, K_SET, MD_HOME, 32'shC);
    `CHK(pos_inc, 48'sd16384)
    i_host.access(1'b1, A_URST, 16'h0001, rd, er);
    `CHK(er, 1'b1)
    pwr_en = 1'b0;
    i_host.access(1'b1, A_URST, 16'h0008, rd, er);
    `CHK(er, 1'b1)
    s = n_save;
    i_host.access(1'b1, A_URST, 16'h0001, rd, er);
    `CHK(busy, 1'b1)
    nv_save = 1'b1;
    cyc(1);
    nv_save = 1'b0;
    for (n = 0; n < 20 && busy !== 1'b0; n++) cyc(1);
    `CHK({er, busy, n_save - s}, {1'b0, 1'b0, 0})
    i_host.access(1'b0, A_WIN + 16'h0010, 16'h0000, rd, er);
    `CHK(rd, USR_PER_REV)
    i_host.access(1'b0, A_WIN, 16'h0000, rd, er);
    `CHK(rd, 16'h0005)
    i_host.access(1'b1, A_URST, 16'h0006, rd, er);
    `CHK({er, busy}, {1'b0, 1'b0})
    i_host.access(1'b0, A_URST, 16'h0000, rd, er);
    `CHK(rd, 16'h0006)
    a = n_apply;
    pwr_en = 1'b1;
    cmd(CH_FB, K_SET, MD_HOME, 32'shC);
    `CHK(pos_inc, 48'sd32768)
    `CHK(n_apply - a, 1)
    pwr_en = 1'b0;
  endtask : t_user_reset
  task automatic t_storage();
    int s, e;
    s = n_save;
    e = n_erase;
    nv_save = 1'b1;
    cyc(1);
    nv_save = 1'b0;
    factory = 1'b1;
    cyc(1);
    factory = 1'b0;
    cyc(3);
    `CHK(n_save - s, 1)
    `CHK({n_erase - e, cyc_req}, {1, 1'b1})
    i_host.access(1'b0, 16'h0002, 16'h0000, rd, er);
    `CHK(er, 1'b1)
  endtask : t_storage
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {nrst, pwr_en, nv_save, factory, cmd_valid, cmd_chan, cmd_kind, mode} = '0;
    cmd_target = 32'sh0;
    safe_in = 8'h00;
    cyc(3);
    nrst = 1'b1;
    t_position();
    t_lock();
    t_software();
    t_user_reset();
    t_storage();
    end_sim();
  end
  // Whole run is about a hundred cycles
  initial begin
    #50000;
    fails++;
    end_sim();
  end
endmodule : drive_access_position_range_test
`default_nettype wire
